/* File: sim/modbus_master_model.sv */
module modbus_master_model
(
  // clock
  input  wire logic       clk,
  // query bytes to the device
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_gap,
  // reply bytes from the device
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       slow;
  logic       tgl_r;
  logic [7:0] rsp[$];
  int         nrsp;

  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_gap = 1'b0;
    tx_ready = 1'b1;
    slow = 1'b0;
    tgl_r = 1'b0;
    nrsp = 0;
  end

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16

  // one byte a clock, crc appended low first, then silence
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = q[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    rx_gap = 1'b1;
    @(negedge clk);
    rx_gap = 1'b0;
  endtask : send

  // reply capture; slow mode accepts every other cycle
  always @(posedge clk)
    if (tx_valid && tx_ready)
    begin
      rsp.push_back(tx_data);
      if (tx_last)
        nrsp++;
    end

  always @(negedge clk)
  begin
    tgl_r <= ~tgl_r;
    tx_ready <= !slow || tgl_r;
  end
endmodule : modbus_master_model

/* File: sim/modbus_operation_command_regs_tb.sv */
module modbus_operation_command_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import modbus_regs_pkg::*;

  logic        ref_clk, nrst, rx_valid, rx_gap, tx_valid, tx_last, tx_ready;
  logic        no_group, applied;
  logic [7:0]  slave_addr, rx_data, tx_data;
  logic [15:0] rd_addr, rd_data;
  logic [15:0] wq[6] = '{16'h0000, 16'h2710, 16'h0000, 16'h4E20, 16'h0007, 16'hA120};
  logic [31:0] drv_in_cmd, drv_out_stat, group_addr, seed_r, cmd_r, grp_r, tmp;
  logic [7:0]  q[$], e[$];
  int          fails, checked, cyc, napp;

  modbus_operation_command_regs i_dut
  (
    .REF_CLK(ref_clk), .NRST(nrst), .SLAVE_ADDR(slave_addr), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_GAP(rx_gap), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_LAST(tx_last), .TX_READY(tx_ready), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
    .DRV_IN_CMD(drv_in_cmd), .DRV_OUT_STAT(drv_out_stat), .GROUP_ADDR(group_addr),
    .NO_GROUP(no_group), .APPLIED(applied)
  );

  modbus_master_model i_master
  (
    .clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_gap(rx_gap),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready)
  );

  always #25 ref_clk = ~ref_clk;

  // applied pulses, counted where the flop output is settled
  always @(negedge ref_clk)
    if (applied === 1'b1)
      napp++;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed_r = {seed_r[30:0], seed_r[31] ^ seed_r[21] ^ seed_r[1] ^ seed_r[0]};
    return seed_r;
  endfunction : rnd

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic hdr(input logic [7:0] sl, fn, input logic [15:0] st, cn, input logic [7:0] bc);
    q = {sl, fn, st[15:8], st[7:0], cn[15:8], cn[7:0], bc};
  endtask : hdr

  task automatic put(input logic [15:0] w);
    q.push_back(w[15:8]);
    q.push_back(w[7:0]);
  endtask : put

  // code 00 normal reply, ff silent, else exception code
  task automatic xfer(input logic bad, input logic [7:0] code);
    logic [15:0] c;
    int          n0, a0;
    n0 = i_master.nrsp;
    a0 = napp;
    i_master.rsp.delete();
    if (code == EXC_NONE)
      e = q[0:5];
    else
      e = {q[0], q[1] | EXC_FLAG, code};
    c = i_master.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    if (code == 8'hFF)
      e.delete();
    i_master.send(q, bad);
    for (int k = 0; k < 60 && i_master.nrsp == n0; k++)
      @(negedge ref_clk);
    repeat (2) @(negedge ref_clk);
    cmp(i_master.rsp.size(), e.size(), "reply length");
    foreach (e[i])
      cmp(i_master.rsp[i], e[i], "reply byte");
    if (code == EXC_NONE)
      cmp(napp - a0, 1, "applied pulse");
  endtask : xfer

  task automatic wr2(input logic [7:0] sl, input logic [15:0] st, input logic [31:0] v,
                     input logic [7:0] code);
    hdr(sl, FUNC_WRITE_MULTI, st, 16'h0002, 8'h04);
    put(v[31:16]);
    put(v[15:0]);
    xfer(1'b0, code);
  endtask : wr2

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    rd_addr = a;
    @(negedge ref_clk);
    cmp(rd_data, exp, "readback");
  endtask : rd

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    seed_r = 32'h0c17_4b10;
    slave_addr = 8'h04;
    rd_addr = 16'h0000;
    drv_out_stat = 32'h0000_0000;
    fails = 0;
    checked = 0;
    cyc = 0;
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    cmp(group_addr, GROUP_NONE, "group reset");
    cmp(no_group, 1'b1, "no group at reset");
    rd(GROUP_HIGH_OFS, 16'hFFFF);
    rd(GROUP_LOW_OFS, 16'hFFFF);
    $display("test reset done");
    hdr(8'h04, FUNC_WRITE_MULTI, 16'h0604, 16'h0006, 8'h0C);
    foreach (wq[i])
      put(wq[i]);
    cmp(i_master.crc16(q), 16'hA91D, "query check value");
    xfer(1'b0, EXC_ILLEGAL_ADDR);
    $display("test unmapped done");
    for (int n = 0; n < 4; n++)
    begin
      i_master.slow = n[0];
      tmp = rnd();
      slave_addr = tmp[7:0] | 8'h20;
      cmd_r = rnd();
      wr2(slave_addr, INPUT_CMD_HIGH_OFS, cmd_r, EXC_NONE);
      cmp(drv_in_cmd, cmd_r, "input command");
      rd(INPUT_CMD_HIGH_OFS, cmd_r[31:16]);
      rd(INPUT_CMD_LOW_OFS, cmd_r[15:0]);
    end
    $display("test command done");
    tmp = rnd();
    grp_r = (tmp % 31) + 1;
    wr2(slave_addr, GROUP_HIGH_OFS, grp_r, EXC_NONE);
    cmp(group_addr, grp_r, "group value");
    cmp(no_group, 1'b0, "group joined");
    wr2(slave_addr, GROUP_HIGH_OFS, 32'h0000_0020, EXC_ILLEGAL_VALUE);
    hdr(slave_addr, FUNC_WRITE_MULTI, GROUP_LOW_OFS, 16'h0001, 8'h02);
    put(16'h0005);
    xfer(1'b0, EXC_ILLEGAL_VALUE);
    cmp(group_addr, grp_r, "group kept");
    cmd_r = rnd();
    wr2(grp_r[7:0], INPUT_CMD_HIGH_OFS, cmd_r, 8'hFF);
    cmp(drv_in_cmd, cmd_r, "group frame applied");
    wr2(slave_addr, GROUP_HIGH_OFS, GROUP_NONE, EXC_NONE);
    cmp(no_group, 1'b1, "group left");
    wr2(grp_r[7:0], INPUT_CMD_HIGH_OFS, ~cmd_r, 8'hFF);
    cmp(drv_in_cmd, cmd_r, "group frame ignored");
    $display("test group done");
    cmd_r = rnd();
    hdr(slave_addr, FUNC_WRITE_MULTI, INPUT_CMD_HIGH_OFS, 16'h0003, 8'h06);
    put(cmd_r[31:16]);
    put(cmd_r[15:0]);
    put(16'h1234);
    xfer(1'b0, EXC_ILLEGAL_ADDR);
    cmp(drv_in_cmd, cmd_r, "partial write");
    drv_out_stat = rnd();
    wr2(slave_addr, OUTPUT_STAT_HIGH_OFS, ~drv_out_stat, EXC_ILLEGAL_ADDR);
    rd(OUTPUT_STAT_HIGH_OFS, drv_out_stat[31:16]);
    rd(OUTPUT_STAT_LOW_OFS, drv_out_stat[15:0]);
    $display("test partial done");
    foreach (wq[i])
    begin
      hdr(slave_addr, FUNC_WRITE_MULTI, INPUT_CMD_HIGH_OFS, i == 0 ? 16'h0000 : 16'h0011, 8'h02);
      put(16'h5555);
      xfer(1'b0, EXC_ILLEGAL_VALUE);
      if (i == 1)
        break;
    end
    hdr(slave_addr, FUNC_WRITE_MULTI, INPUT_CMD_HIGH_OFS, 16'h0002, 8'h03);
    put(16'h1111);
    q.push_back(8'h22);
    xfer(1'b0, EXC_ILLEGAL_VALUE);
    wr2(slave_addr, INPUT_CMD_HIGH_OFS, ~cmd_r, EXC_NONE);
    hdr(slave_addr, 8'h03, INPUT_CMD_HIGH_OFS, 16'h0002, 8'h04);
    xfer(1'b0, EXC_ILLEGAL_FUNC);
    cmp(drv_in_cmd, ~cmd_r, "refused frame kept");
    wr2(BROADCAST_ADDR, INPUT_CMD_HIGH_OFS, cmd_r, 8'hFF);
    cmp(drv_in_cmd, cmd_r, "broadcast applied");
    hdr(slave_addr, FUNC_WRITE_MULTI, INPUT_CMD_HIGH_OFS, 16'h0002, 8'h04);
    put(16'hDEAD);
    put(16'hBEEF);
    xfer(1'b1, 8'hFF);
    cmp(drv_in_cmd, cmd_r, "bad check dropped");
    $display("test refusal done");
    summarize();
  end
endmodule : modbus_operation_command_regs_tb

/* File: sim/modbus_regs_asserts.sv */
module modbus_regs_asserts
(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  // watched ports
  input  wire logic        RX_GAP,
  input  wire logic        TX_VALID,
  input  wire logic [7:0]  TX_DATA,
  input  wire logic        TX_LAST,
  input  wire logic        TX_READY,
  input  wire logic [15:0] RD_ADDR,
  input  wire logic [15:0] RD_DATA,
  input  wire logic [31:0] DRV_IN_CMD,
  input  wire logic [31:0] DRV_OUT_STAT,
  input  wire logic [31:0] GROUP_ADDR,
  input  wire logic        NO_GROUP,
  input  wire logic        APPLIED
);
  timeunit 1ns;
  timeprecision 1ns;
  import modbus_regs_pkg::*;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  a_no_group_flag: assert property (NO_GROUP == (GROUP_ADDR == GROUP_NONE))
    else $error("no-group flag disagrees with group value");
  a_group_range: assert property (GROUP_ADDR == GROUP_NONE || GROUP_ADDR inside {[1:31]})
    else $error("group value out of range");
  a_last_offered: assert property (TX_LAST |-> TX_VALID)
    else $error("last flag without offered byte");
  a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("reply byte dropped or changed while stalled");
  a_gap_quiet: assert property (RX_GAP && !TX_VALID |=> !TX_VALID)
    else $error("reply offered right after frame end");
  a_cmd_applied: assert property ($changed(DRV_IN_CMD) |-> ##[0:18] APPLIED)
    else $error("input command changed outside a write");
  a_group_applied: assert property ($changed(GROUP_ADDR) |-> ##[0:18] APPLIED)
    else $error("group value changed outside a write");
  a_stat_high: assert property (RD_ADDR == OUTPUT_STAT_HIGH_OFS |=>
    RD_DATA == $past(DRV_OUT_STAT[31:16])) else $error("status upper readback wrong");
  a_cmd_low: assert property (RD_ADDR == INPUT_CMD_LOW_OFS |=>
    RD_DATA == $past(DRV_IN_CMD[15:0])) else $error("command lower readback wrong");
  a_group_high: assert property (RD_ADDR == GROUP_HIGH_OFS |=>
    RD_DATA == $past(GROUP_ADDR[31:16])) else $error("group upper readback wrong");
endmodule : modbus_regs_asserts

bind modbus_operation_command_regs modbus_regs_asserts i_chk
(
  .REF_CLK(REF_CLK), .NRST(NRST), .RX_GAP(RX_GAP), .TX_VALID(TX_VALID),
  .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY), .RD_ADDR(RD_ADDR),
  .RD_DATA(RD_DATA), .DRV_IN_CMD(DRV_IN_CMD), .DRV_OUT_STAT(DRV_OUT_STAT),
  .GROUP_ADDR(GROUP_ADDR), .NO_GROUP(NO_GROUP), .APPLIED(APPLIED)
);

/* File: src/crc16_engine.sv */
module crc16_engine
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // byte feed
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // result
  output logic      [15:0] crc_r,
  output logic      [15:0] crc_nxt
);
  import modbus_regs_pkg::*;

  logic [15:0] fold;
  logic [15:0] upd;

  // ----------------------------------------------------------------
  // reflected crc-16, one byte per cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    fold = crc_r ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      fold = fold[0] ? ((fold >> 1) ^ CRC_POLY) : (fold >> 1);
    end
    upd = fold;
    if (clr)
      crc_nxt = CRC_INIT;
    else if (en)
      crc_nxt = upd;
    else
      crc_nxt = crc_r;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      crc_r <= CRC_INIT;
    else
      crc_r <= crc_nxt;
  end

endmodule : crc16_engine

/* File: src/modbus_operation_command_regs.sv */
module modbus_operation_command_regs
(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  // station address
  input  wire logic [7:0]  SLAVE_ADDR,
  // received bytes from the serial receiver
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_GAP,
  // reply bytes to the serial transmitter
  output logic             TX_VALID,
  output logic      [7:0]  TX_DATA,
  output logic             TX_LAST,
  input  wire logic        TX_READY,
  // register readback for the read handler
  input  wire logic [15:0] RD_ADDR,
  output logic      [15:0] RD_DATA,
  // driver side
  output logic      [31:0] DRV_IN_CMD,
  input  wire logic [31:0] DRV_OUT_STAT,
  output logic      [31:0] GROUP_ADDR,
  output logic             NO_GROUP,
  output logic             APPLIED
);
  import modbus_regs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_t      state_r,    state_nxt;
  query_t      hdr_r,      hdr_nxt;
  logic [5:0]  pos_r,      pos_nxt;
  logic        ovf_r,      ovf_nxt;
  logic [4:0]  idx_r,      idx_nxt;
  logic [7:0]  exc_r,      exc_nxt;
  logic        skip_r,     skip_nxt;
  logic        reply_r,    reply_nxt;
  logic [15:0] grp_hi_r,   grp_hi_nxt;
  logic [15:0] grp_lo_r,   grp_lo_nxt;
  logic [15:0] pend_hi_r,  pend_hi_nxt;
  logic        pend_vld_r, pend_vld_nxt;
  logic [15:0] in_hi_r,    in_hi_nxt;
  logic [15:0] in_lo_r,    in_lo_nxt;
  logic [2:0]  tx_pos_r,   tx_pos_nxt;
  logic [7:0]  tx_data_r,  tx_data_nxt;
  logic        applied_r,  applied_nxt;
  logic [15:0] rd_data_r,  rd_data_nxt;

  logic [7:0]  rxbuf_hi [16];
  logic [7:0]  rxbuf_lo [16];
  logic        buf_we;
  logic [5:0]  buf_ofs;

  logic        rx_crc_clr, rx_crc_en;
  logic [15:0] rx_crc;
  logic        tx_crc_clr, tx_crc_en;
  logic [15:0] tx_crc, tx_crc_nxt;

  logic [15:0] wr_addr;
  logic [15:0] wr_word;
  logic [31:0] grp_cand;
  logic        grp_none;
  logic        hit;
  logic [7:0]  exc_fin;
  logic [2:0]  crc_lo_pos;
  logic [2:0]  nxt_pos;

  // ----------------------------------------------------------------
  // crc engines
  // ----------------------------------------------------------------
  crc16_engine u_rx_crc
  (
    .clk     (REF_CLK),
    .nrst    (NRST),
    .clr     (rx_crc_clr),
    .en      (rx_crc_en),
    .data    (RX_DATA),
    .crc_r   (rx_crc),
    .crc_nxt ()
  );

  crc16_engine u_tx_crc
  (
    .clk     (REF_CLK),
    .nrst    (NRST),
    .clr     (tx_crc_clr),
    .en      (tx_crc_en),
    .data    (tx_data_r),
    .crc_r   (tx_crc),
    .crc_nxt (tx_crc_nxt)
  );

  // ----------------------------------------------------------------
  // reply byte selection
  // ----------------------------------------------------------------
  function automatic logic [7:0] reply_byte(input logic [2:0] p, input logic [7:0] e,
                                            input query_t q, input logic [15:0] crc_v);
    logic [7:0] b;
    b = 8'h00;
    if (e != EXC_NONE)
    begin
      unique case (p)
        3'h0:    b = q.slave;
        3'h1:    b = q.func | EXC_FLAG;
        3'h2:    b = e;
        3'h3:    b = crc_v[7:0];
        default: b = crc_v[15:8];
      endcase
    end
    else
    begin
      unique case (p)
        3'h0:    b = q.slave;
        3'h1:    b = q.func;
        3'h2:    b = q.start[15:8];
        3'h3:    b = q.start[7:0];
        3'h4:    b = q.count[15:8];
        3'h5:    b = q.count[7:0];
        3'h6:    b = crc_v[7:0];
        default: b = crc_v[15:8];
      endcase
    end
    return b;
  endfunction : reply_byte

  assign grp_none   = ({grp_hi_r, grp_lo_r} == GROUP_NONE);
  assign hit        = (hdr_r.slave == SLAVE_ADDR) || (hdr_r.slave == BROADCAST_ADDR)
                      || (!grp_none && (hdr_r.slave == grp_lo_r[7:0]));
  assign buf_ofs    = pos_r - POS_DATA;
  assign wr_addr    = hdr_r.start + 16'(idx_r);
  assign wr_word    = {rxbuf_hi[idx_r[3:0]], rxbuf_lo[idx_r[3:0]]};
  assign grp_cand   = {pend_hi_r, wr_word};
  assign crc_lo_pos = (exc_r != EXC_NONE) ? TX_CRC_LO_EXC : TX_CRC_LO_NORMAL;
  assign nxt_pos    = tx_pos_r + 3'h1;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt    = state_r;
    hdr_nxt      = hdr_r;
    pos_nxt      = pos_r;
    ovf_nxt      = ovf_r;
    idx_nxt      = idx_r;
    exc_nxt      = exc_r;
    skip_nxt     = skip_r;
    reply_nxt    = reply_r;
    grp_hi_nxt   = grp_hi_r;
    grp_lo_nxt   = grp_lo_r;
    pend_hi_nxt  = pend_hi_r;
    pend_vld_nxt = pend_vld_r;
    in_hi_nxt    = in_hi_r;
    in_lo_nxt    = in_lo_r;
    tx_pos_nxt   = tx_pos_r;
    tx_data_nxt  = tx_data_r;
    applied_nxt  = 1'b0;
    buf_we       = 1'b0;
    rx_crc_clr   = 1'b0;
    rx_crc_en    = 1'b0;
    tx_crc_clr   = 1'b0;
    tx_crc_en    = 1'b0;
    exc_fin      = exc_r;
    unique case (state_r)
      ST_RX:
      begin
        if (RX_GAP)
        begin
          pos_nxt    = 6'h00;
          ovf_nxt    = 1'b0;
          rx_crc_clr = 1'b1;
          if ((pos_r >= FRAME_MIN) && !ovf_r && (rx_crc == CRC_GOOD) && hit)
          begin
            state_nxt = ST_EXEC;
            idx_nxt   = 5'h00;
            reply_nxt = (hdr_r.slave == SLAVE_ADDR);
            skip_nxt  = 1'b1;
            exc_nxt   = EXC_NONE;
            if (hdr_r.func != FUNC_WRITE_MULTI)
              exc_nxt = EXC_ILLEGAL_FUNC;
            else if ((hdr_r.count == 16'h0000) || (hdr_r.count > MAX_REGS))
              exc_nxt = EXC_ILLEGAL_VALUE;
            else if (hdr_r.bcnt != {hdr_r.count[6:0], 1'b0})
              exc_nxt = EXC_ILLEGAL_VALUE;
            else if ({2'b00, pos_r} != (hdr_r.bcnt + FRAME_OVERHEAD))
              exc_nxt = EXC_ILLEGAL_VALUE;
            else
              skip_nxt = 1'b0;
          end
        end
        else if (RX_VALID)
        begin
          if (pos_r == FRAME_MAX)
            ovf_nxt = 1'b1;
          else
          begin
            pos_nxt   = pos_r + 6'h01;
            rx_crc_en = 1'b1;
            unique case (pos_r)
              POS_SLAVE:    hdr_nxt.slave        = RX_DATA;
              POS_FUNC:     hdr_nxt.func         = RX_DATA;
              POS_START_HI: hdr_nxt.start[15:8]  = RX_DATA;
              POS_START_LO: hdr_nxt.start[7:0]   = RX_DATA;
              POS_COUNT_HI: hdr_nxt.count[15:8]  = RX_DATA;
              POS_COUNT_LO: hdr_nxt.count[7:0]   = RX_DATA;
              POS_BCNT:     hdr_nxt.bcnt         = RX_DATA;
              default:      buf_we = (pos_r < POS_DATA_END);
            endcase
          end
        end
      end
      ST_EXEC:
      begin
        if (skip_r || (16'(idx_r) == hdr_r.count))
        begin
          // a lone upper group half is never committed
          if (pend_vld_r && (exc_r == EXC_NONE))
            exc_fin = EXC_ILLEGAL_VALUE;
          exc_nxt      = exc_fin;
          pend_vld_nxt = 1'b0;
          applied_nxt  = !skip_r;
          tx_crc_clr   = 1'b1;
          if (reply_r)
          begin
            state_nxt   = ST_TX;
            tx_pos_nxt  = 3'h0;
            tx_data_nxt = hdr_r.slave;
          end
          else
            state_nxt = ST_RX;
        end
        else
        begin
          idx_nxt      = idx_r + 5'h01;
          pend_vld_nxt = 1'b0;
          // registers live in flops only, nothing is saved
          unique case (wr_addr)
            GROUP_HIGH_OFS:
            begin
              pend_hi_nxt  = wr_word;
              pend_vld_nxt = 1'b1;
            end
            GROUP_LOW_OFS:
            begin
              if (pend_vld_r && ((grp_cand == GROUP_NONE)
                  || ((grp_cand >= GROUP_MIN) && (grp_cand <= GROUP_MAX))))
              begin
                grp_hi_nxt = pend_hi_r;
                grp_lo_nxt = wr_word;
              end
              else if (exc_r == EXC_NONE)
                exc_nxt = EXC_ILLEGAL_VALUE;
            end
            INPUT_CMD_HIGH_OFS: in_hi_nxt = wr_word;
            INPUT_CMD_LOW_OFS:  in_lo_nxt = wr_word;
            default:
            begin
              if (exc_r == EXC_NONE)
                exc_nxt = EXC_ILLEGAL_ADDR;
            end
          endcase
        end
      end
      ST_TX:
      begin
        if (TX_READY)
        begin
          tx_crc_en = (tx_pos_r < crc_lo_pos);
          if (TX_LAST)
            state_nxt = ST_RX;
          else
          begin
            tx_pos_nxt = nxt_pos;
            if (nxt_pos == crc_lo_pos)
              tx_data_nxt = tx_crc_nxt[7:0];
            else
              tx_data_nxt = reply_byte(nxt_pos, exc_r, hdr_r, tx_crc);
          end
        end
      end
    endcase
  end

  always_comb
  begin
    unique case (RD_ADDR)
      GROUP_HIGH_OFS:       rd_data_nxt = grp_hi_r;
      GROUP_LOW_OFS:        rd_data_nxt = grp_lo_r;
      INPUT_CMD_HIGH_OFS:   rd_data_nxt = in_hi_r;
      INPUT_CMD_LOW_OFS:    rd_data_nxt = in_lo_r;
      OUTPUT_STAT_HIGH_OFS: rd_data_nxt = DRV_OUT_STAT[31:16];
      OUTPUT_STAT_LOW_OFS:  rd_data_nxt = DRV_OUT_STAT[15:0];
      default:              rd_data_nxt = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_r    <= ST_RX;
      hdr_r      <= '0;
      pos_r      <= 6'h00;
      ovf_r      <= 1'b0;
      idx_r      <= 5'h00;
      exc_r      <= EXC_NONE;
      skip_r     <= 1'b0;
      reply_r    <= 1'b0;
      grp_hi_r   <= GROUP_RESET;
      grp_lo_r   <= GROUP_RESET;
      pend_hi_r  <= 16'h0000;
      pend_vld_r <= 1'b0;
      in_hi_r    <= INPUT_CMD_RESET;
      in_lo_r    <= INPUT_CMD_RESET;
      tx_pos_r   <= 3'h0;
      tx_data_r  <= 8'h00;
      applied_r  <= 1'b0;
      rd_data_r  <= 16'h0000;
    end
    else
    begin
      state_r    <= state_nxt;
      hdr_r      <= hdr_nxt;
      pos_r      <= pos_nxt;
      ovf_r      <= ovf_nxt;
      idx_r      <= idx_nxt;
      exc_r      <= exc_nxt;
      skip_r     <= skip_nxt;
      reply_r    <= reply_nxt;
      grp_hi_r   <= grp_hi_nxt;
      grp_lo_r   <= grp_lo_nxt;
      pend_hi_r  <= pend_hi_nxt;
      pend_vld_r <= pend_vld_nxt;
      in_hi_r    <= in_hi_nxt;
      in_lo_r    <= in_lo_nxt;
      tx_pos_r   <= tx_pos_nxt;
      tx_data_r  <= tx_data_nxt;
      applied_r  <= applied_nxt;
      rd_data_r  <= rd_data_nxt;
    end
  end

  // data bytes, high byte at even offset
  always_ff @(posedge REF_CLK)
  begin
    if (buf_we)
    begin
      if (buf_ofs[0])
        rxbuf_lo[buf_ofs[4:1]] <= RX_DATA;
      else
        rxbuf_hi[buf_ofs[4:1]] <= RX_DATA;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign TX_VALID   = (state_r == ST_TX);
  assign TX_DATA    = tx_data_r;
  assign TX_LAST    = (state_r == ST_TX) && (tx_pos_r == crc_lo_pos + 3'h1);
  assign RD_DATA    = rd_data_r;
  assign DRV_IN_CMD = {in_hi_r, in_lo_r};
  assign GROUP_ADDR = {grp_hi_r, grp_lo_r};
  assign NO_GROUP   = grp_none;
  assign APPLIED    = applied_r;

endmodule : modbus_operation_command_regs

/* File: src/modbus_regs_pkg.sv */
// Behaviour
// - write query holds slave, function 10h, start, count, byte count, data, CRC.
// - starting register address arrives high byte first.
// - register count is two bytes, high first, counting consecutive 16-bit registers.
// - byte count equals twice the register count; data holds that many bytes.
// - data lays out registers ascending, each high byte before low byte.
// - every frame ends in CRC-16, low byte sent first.
// - each 32-bit datum spans two consecutive 16-bit registers.
// - even address holds upper half, following odd address lower half.
// - operation commands live only in volatile flops, never saved.
// - group value -1 means no group; group frames are not acted on.
// - group pair 0030h/0031h accepts 1 to 31, the parent slave address.
// - group pair resets to FFFFh in both halves.
// - query sent to our group is acted on like our own.
// - input command pair 007Ch/007Dh is read/write and drives the input signals.
// - output status pair 007Eh/007Fh is read only, shows live output status.
// - at most sixteen registers per write, stored in ascending address order.
// - out-of-range values give an exception while other registers may be written.
package modbus_regs_pkg;

  // ----------------------------------------------------------------
  // protocol codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  FUNC_WRITE_MULTI  = 8'h10;
  localparam logic [7:0]  EXC_FLAG          = 8'h80;
  localparam logic [7:0]  EXC_NONE          = 8'h00;
  localparam logic [7:0]  EXC_ILLEGAL_FUNC  = 8'h01;
  localparam logic [7:0]  EXC_ILLEGAL_ADDR  = 8'h02;
  localparam logic [7:0]  EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0]  BROADCAST_ADDR    = 8'h00;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] GROUP_HIGH_OFS    = 16'h0030;
  localparam logic [15:0] GROUP_LOW_OFS     = 16'h0031;
  localparam logic [15:0] INPUT_CMD_HIGH_OFS  = 16'h007C;
  localparam logic [15:0] INPUT_CMD_LOW_OFS   = 16'h007D;
  localparam logic [15:0] OUTPUT_STAT_HIGH_OFS = 16'h007E;
  localparam logic [15:0] OUTPUT_STAT_LOW_OFS  = 16'h007F;
  localparam logic [15:0] GROUP_RESET       = 16'hFFFF;
  localparam logic [15:0] INPUT_CMD_RESET   = 16'h0000;
  localparam logic [31:0] GROUP_NONE        = 32'hFFFF_FFFF;
  localparam logic [31:0] GROUP_MIN         = 32'h0000_0001;
  localparam logic [31:0] GROUP_MAX         = 32'h0000_001F;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam logic [15:0] MAX_REGS          = 16'h0010;
  localparam logic [5:0]  POS_SLAVE         = 6'h00;
  localparam logic [5:0]  POS_FUNC          = 6'h01;
  localparam logic [5:0]  POS_START_HI      = 6'h02;
  localparam logic [5:0]  POS_START_LO      = 6'h03;
  localparam logic [5:0]  POS_COUNT_HI      = 6'h04;
  localparam logic [5:0]  POS_COUNT_LO      = 6'h05;
  localparam logic [5:0]  POS_BCNT          = 6'h06;
  localparam logic [5:0]  POS_DATA          = 6'h07;
  localparam logic [5:0]  POS_DATA_END      = 6'h27;
  localparam logic [5:0]  FRAME_MAX         = 6'h29;
  localparam logic [5:0]  FRAME_MIN         = 6'h04;
  localparam logic [7:0]  FRAME_OVERHEAD    = 8'h09;
  localparam logic [2:0]  TX_CRC_LO_NORMAL  = 3'h6;
  localparam logic [2:0]  TX_CRC_LO_EXC     = 3'h3;

  // ----------------------------------------------------------------
  // crc
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_INIT          = 16'hFFFF;
  localparam logic [15:0] CRC_POLY          = 16'hA001;
  localparam logic [15:0] CRC_GOOD          = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  slave;
    logic [7:0]  func;
    logic [15:0] start;
    logic [15:0] count;
    logic [7:0]  bcnt;
  } query_t;

  typedef enum logic [1:0] {
    ST_RX,
    ST_EXEC,
    ST_TX
  } state_t;

endpackage : modbus_regs_pkg
